// >>> hw/eym_pkg.sv
// Purpose: shared constants and carriers for the eye monitor register bank
// Assumes: byte-wide register port behind the serial configuration port
// Notes:   offsets are the register addresses as seen on that port
`default_nettype none

package eym_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] EYM_OFS_CTL_ONE   = 8'h22;
  localparam logic [7:0] EYM_OFS_CTL_TWO   = 8'h23;
  localparam logic [7:0] EYM_OFS_CTL_THREE = 8'h24;
  localparam logic [7:0] EYM_OFS_HITS_HI   = 8'h25;
  localparam logic [7:0] EYM_OFS_HITS_LO   = 8'h26;
  localparam logic [7:0] EYM_OFS_RSVD_A    = 8'h27;
  localparam logic [7:0] EYM_OFS_RSVD_B    = 8'h28;
  localparam logic [7:0] EYM_OFS_TIMER     = 8'h29;
  localparam logic [7:0] EYM_OFS_HORIZ     = 8'h2a;
  localparam logic [7:0] EYM_OFS_VERT      = 8'h2b;
  localparam logic [7:0] EYM_OFS_CTL_FOUR  = 8'h2c;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int EYM_BIT_OVERRIDE  = 7;
  localparam int EYM_BIT_HIGH_RATE = 6;
  localparam int EYM_BIT_AUTO_STEP = 7;
  localparam int EYM_BIT_VLIMIT    = 4;
  localparam int EYM_BIT_NO_OPEN   = 3;
  localparam int EYM_BIT_NO_HITS   = 2;
  localparam int EYM_BIT_MEASURE   = 1;
  localparam int EYM_BIT_ACTIVE    = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] EYM_RST_CTL_ONE   = 8'h00;
  localparam logic [7:0] EYM_RST_CTL_TWO   = 8'h40;
  localparam logic [1:0] EYM_RST_CTL3_RSVD = 2'h0;
  localparam logic [7:0] EYM_RST_RSVD_AB   = 8'h48;
  localparam logic [7:0] EYM_RST_TIMER     = 8'h01;
  localparam logic [7:0] EYM_RST_CTL_FOUR  = 8'h00;

  // ****************************************************************
  // counts
  // ****************************************************************
  localparam int         EYM_TICKS_PER_UNIT = 256;
  localparam logic [5:0] EYM_DAC_CENTRE     = 6'h20;
  localparam logic [6:0] EYM_OPEN_NONE_HIT  = 7'h40;
  localparam logic [6:0] EYM_OPEN_MAX_VALID = 7'h3f;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eym_req_s;

  typedef struct packed {
    logic [5:0] phase;
    logic [5:0] voltage;
  } eym_dac_s;

endpackage : eym_pkg

`default_nettype wire

// >>> hw/eym_hit_counter.sv
// Purpose: timed hit counter for one phase/voltage point
// Assumes: hit and divided vco clock arrive as asynchronous levels
// Notes:   interval of zero ends the count at once
`default_nettype none

module eym_hit_counter
  import eym_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // analog side
  input  wire logic        hit_in,
  input  wire logic        vco_div_in,
  // control
  input  wire logic        start,
  input  wire logic [7:0]  interval,
  // result
  output logic             busy,
  output logic             done,
  output logic [15:0]      hits
);

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  logic hit_s1_q, hit_s2_q, hit_s3_q;
  logic div_s1_q, div_s2_q, div_s3_q;
  logic [15:0] ticks_q;
  logic tick, hit_edge;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      {hit_s1_q, hit_s2_q, hit_s3_q} <= 3'h0;
      {div_s1_q, div_s2_q, div_s3_q} <= 3'h0;
    end
    else
    begin
      hit_s1_q <= hit_in;
      hit_s2_q <= hit_s1_q;
      hit_s3_q <= hit_s2_q;
      div_s1_q <= vco_div_in;
      div_s2_q <= div_s1_q;
      div_s3_q <= div_s2_q;
    end
  end

  // edges taken past the second flop only
  assign tick     = div_s2_q & ~div_s3_q;
  assign hit_edge = hit_s2_q & ~hit_s3_q;

  // ****************************************************************
  // interval timer and hit accumulator
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      busy    <= 1'b0;
      done    <= 1'b0;
      hits    <= 16'h0000;
      ticks_q <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy    <= 1'b1;
        hits    <= 16'h0000;
        ticks_q <= 16'(interval) * 16'(EYM_TICKS_PER_UNIT);
      end
      else if (busy)
      begin
        // saturate so a long interval never wraps to a low count
        if (hit_edge && hits != 16'hffff)
          hits <= hits + 16'h0001;
        if (ticks_q == 16'h0000)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else if (tick)
          ticks_q <= ticks_q - 16'h0001;
      end
    end
  end

  chk_interval_len: assert property (@(posedge mclk) disable iff (rst)
    start && interval == 8'h01 |=> busy [*8])
    else $error("count interval ended too early");

endmodule : eym_hit_counter

`default_nettype wire

// >>> hw/eym_opening_scan.sv
// Purpose: horizontal then vertical eye opening sweep
// Assumes: one timed count per point from the hit counter
// Notes:   horizontal sweep at centre voltage, vertical at centre phase
`default_nettype none

module eym_opening_scan
  import eym_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // control
  input  wire logic        start,
  input  wire logic [3:0]  threshold,
  // hit counter
  input  wire logic        cnt_done,
  input  wire logic [15:0] cnt_hits,
  output logic             cnt_start,
  // results
  output eym_dac_s         dac,
  output logic             busy,
  output logic             done,
  output logic [7:0]       horiz,
  output logic [7:0]       vert,
  output logic             no_hits,
  output logic             no_open,
  output logic             vlimit
);

  typedef enum logic [2:0] {SC_IDLE, SC_H_REQ, SC_H_WAIT, SC_V_REQ,
                            SC_V_WAIT, SC_FINISH} eym_scan_e;

  eym_scan_e  state_q;
  logic [5:0] idx_q;
  logic [6:0] h_open_q, v_zero_q;
  logic       any_hit_q, any_zero_q;
  logic [15:0] thr;
  logic        closed;

  // a threshold of zero would close every point, so treat it as one
  assign thr    = (threshold == 4'h0) ? 16'h0001 : 16'(threshold);
  assign closed = cnt_hits >= thr;

  // ****************************************************************
  // sweep sequencer
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q    <= SC_IDLE;
      idx_q      <= 6'h00;
      h_open_q   <= 7'h00;
      v_zero_q   <= 7'h00;
      any_hit_q  <= 1'b0;
      any_zero_q <= 1'b0;
      cnt_start  <= 1'b0;
      done       <= 1'b0;
      horiz      <= 8'h00;
      vert       <= 8'h00;
      {no_hits, no_open, vlimit} <= 3'h0;
    end
    else
    begin
      cnt_start <= 1'b0;
      done      <= 1'b0;
      unique case (state_q)
        SC_IDLE:
          if (start)
          begin
            idx_q      <= 6'h00;
            h_open_q   <= 7'h00;
            v_zero_q   <= 7'h00;
            any_hit_q  <= 1'b0;
            any_zero_q <= 1'b0;
            state_q    <= SC_H_REQ;
          end
        SC_H_REQ:
        begin
          cnt_start <= 1'b1;
          state_q   <= SC_H_WAIT;
        end
        SC_H_WAIT:
          if (cnt_done)
          begin
            if (!closed)
              h_open_q <= h_open_q + 7'h01;
            if (cnt_hits != 16'h0000)
              any_hit_q <= 1'b1;
            else
              any_zero_q <= 1'b1;
            idx_q   <= idx_q + 6'h01;
            state_q <= (idx_q == 6'h3f) ? SC_V_REQ : SC_H_REQ;
          end
        SC_V_REQ:
        begin
          cnt_start <= 1'b1;
          state_q   <= SC_V_WAIT;
        end
        SC_V_WAIT:
          if (cnt_done)
          begin
            if (cnt_hits == 16'h0000)
              v_zero_q <= v_zero_q + 7'h01;
            idx_q   <= idx_q + 6'h01;
            state_q <= (idx_q == 6'h3f) ? SC_FINISH : SC_V_REQ;
          end
        SC_FINISH:
        begin
          no_hits <= !any_hit_q;
          no_open <= any_hit_q && !any_zero_q;
          if (!any_hit_q)
            horiz <= {1'b0, EYM_OPEN_NONE_HIT};
          else if (!any_zero_q)
            horiz <= 8'h00;
          else if (h_open_q > EYM_OPEN_MAX_VALID)
            horiz <= {1'b0, EYM_OPEN_MAX_VALID};
          else
            horiz <= {1'b0, h_open_q};
          vlimit <= (v_zero_q == EYM_OPEN_NONE_HIT);
          vert   <= {1'b0, v_zero_q};
          done    <= 1'b1;
          state_q <= SC_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_q != SC_IDLE);
  assign dac.phase   = (state_q == SC_V_REQ || state_q == SC_V_WAIT)
                       ? EYM_DAC_CENTRE : idx_q;
  assign dac.voltage = (state_q == SC_V_REQ || state_q == SC_V_WAIT)
                       ? idx_q : EYM_DAC_CENTRE;

  chk_horiz_none: assert property (@(posedge mclk) disable iff (rst)
    done && horiz == 8'h40 |-> no_hits)
    else $error("horizontal 64 without no-hits flag");

  chk_vert_limit: assert property (@(posedge mclk) disable iff (rst)
    done |-> (vert == 8'h40) == vlimit)
    else $error("vertical 64 and limit flag disagree");

endmodule : eym_opening_scan

`default_nettype wire

// >>> hw/eym_regs.sv
// Purpose: eye monitor control and status register bank
// Assumes: register port strobes come from same-clock serial port logic
// Notes:   read data appears one cycle after the read strobe
//
// Operation
// - without override, the device drives phase and voltage dacs itself.
// - with override set, the register phase and voltage fields drive dacs.
// - high-rate filter bit picks standard mode or extra filtering.
// - auto-step mode lets the device set dac points without software.
// - vertical limit flag set when no eye top or bottom found.
// - no-opening flag set when no horizontal point showed zero hits.
// - no-hits flag set when no horizontal point showed any hit.
// - measure bit starts a sweep, reads one while busy, clears when done.
// - active bit shows counting, self-clears; software, auto-step or the sweep sets it.
// - sixteen-bit hit count is read as an upper then lower byte.
// - in auto-step mode a low-byte read steps and restarts counting.
// - count interval is in units of 256 divided vco clocks, resets to one.
// - horizontal result is 1..63, 64 with no-hits, 0 with no-opening.
// - vertical result is 0..63, 64 with the vertical limit flag.
// - a four-bit threshold sets hits needed to call a point closed.
`default_nettype none

module eym_regs
  import eym_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register port
  input  wire eym_req_s    req,
  output logic [7:0]       rdata,
  // analog side
  input  wire logic        hit_in,
  input  wire logic        vco_div_in,
  output eym_dac_s         dac_out,
  output logic             high_rate_filter
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0]  ctl_one_q, ctl_two_q, rsvd_a_q, rsvd_b_q;
  logic [7:0]  timer_q, ctl_four_q;
  logic        auto_step_q, auto_step_prev_q;
  logic [1:0]  ctl3_rsvd_q;
  logic        measure_q, active_q;
  logic [15:0] hit_count_q;
  logic [11:0] auto_pt_q;
  logic [7:0]  rdata_d;
  eym_dac_s    dac_d;

  logic        wr_one, wr_two, wr_three, wr_rsvd_a, wr_rsvd_b;
  logic        wr_timer, wr_four, rd_low;
  logic        sw_count, sw_measure, auto_kick, auto_next, count_start;

  logic        cnt_busy, cnt_done;
  logic [15:0] cnt_hits;
  logic        scan_start, scan_cnt_start, scan_busy, scan_done;
  eym_dac_s    scan_dac;
  logic [7:0]  horiz, vert;
  logic        no_hits, no_open, vlimit;

  // ****************************************************************
  // decode
  // ****************************************************************
  assign wr_one    = req.wr && req.addr == EYM_OFS_CTL_ONE;
  assign wr_two    = req.wr && req.addr == EYM_OFS_CTL_TWO;
  assign wr_three  = req.wr && req.addr == EYM_OFS_CTL_THREE;
  assign wr_rsvd_a = req.wr && req.addr == EYM_OFS_RSVD_A;
  assign wr_rsvd_b = req.wr && req.addr == EYM_OFS_RSVD_B;
  assign wr_timer  = req.wr && req.addr == EYM_OFS_TIMER;
  assign wr_four   = req.wr && req.addr == EYM_OFS_CTL_FOUR;
  assign rd_low    = req.rd && req.addr == EYM_OFS_HITS_LO;

  // ****************************************************************
  // plain read/write registers
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctl_one_q   <= EYM_RST_CTL_ONE;
      ctl_two_q   <= EYM_RST_CTL_TWO;
      rsvd_a_q    <= EYM_RST_RSVD_AB;
      rsvd_b_q    <= EYM_RST_RSVD_AB;
      timer_q     <= EYM_RST_TIMER;
      ctl_four_q  <= EYM_RST_CTL_FOUR;
      ctl3_rsvd_q <= EYM_RST_CTL3_RSVD;
      auto_step_q <= 1'b0;
    end
    else
    begin
      if (wr_one)
        ctl_one_q <= req.wdata;
      if (wr_two)
        ctl_two_q <= req.wdata;
      if (wr_rsvd_a)
        rsvd_a_q <= req.wdata;
      if (wr_rsvd_b)
        rsvd_b_q <= req.wdata;
      if (wr_timer)
        timer_q <= req.wdata;
      if (wr_four)
        ctl_four_q <= req.wdata;
      if (wr_three)
      begin
        auto_step_q <= req.wdata[EYM_BIT_AUTO_STEP];
        ctl3_rsvd_q <= req.wdata[6:5];
      end
    end
  end

  // ****************************************************************
  // counting control
  // ****************************************************************
  // a software start while a count runs is dropped rather than restarting it
  assign sw_count   = wr_three && req.wdata[EYM_BIT_ACTIVE] && !auto_step_q
                      && !active_q && !measure_q;
  assign sw_measure = wr_three && req.wdata[EYM_BIT_MEASURE]
                      && !measure_q && !active_q;
  assign auto_kick  = auto_step_q && !auto_step_prev_q && !measure_q;
  assign auto_next  = rd_low && auto_step_q && !active_q
                      && !measure_q;
  assign count_start = sw_count || auto_kick || auto_next
                       || scan_cnt_start;
  assign scan_start  = sw_measure;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      active_q         <= 1'b0;
      measure_q        <= 1'b0;
      auto_step_prev_q <= 1'b0;
      auto_pt_q        <= 12'h000;
    end
    else
    begin
      auto_step_prev_q <= auto_step_q;
      // set wins over the self-clear
      if (count_start)
        active_q <= 1'b1;
      else if (cnt_done)
        active_q <= 1'b0;
      if (sw_measure)
        measure_q <= 1'b1;
      else if (scan_done)
        measure_q <= 1'b0;
      if (auto_kick)
        auto_pt_q <= 12'h000;
      else if (auto_next)
        auto_pt_q <= auto_pt_q + 12'h001;
    end
  end

  // ****************************************************************
  // hit count capture
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      hit_count_q <= 16'h0000;
    else if (cnt_done)
      hit_count_q <= cnt_hits;
  end

  // ****************************************************************
  // dac steering
  // ****************************************************************
  always_comb
  begin
    if (ctl_one_q[EYM_BIT_OVERRIDE])
    begin
      dac_d.phase   = ctl_one_q[5:0];
      dac_d.voltage = ctl_two_q[5:0];
    end
    else if (scan_busy)
      dac_d = scan_dac;
    else
    begin
      dac_d.phase   = auto_pt_q[5:0];
      dac_d.voltage = auto_pt_q[11:6];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dac_out          <= '0;
      high_rate_filter <= 1'b0;
    end
    else
    begin
      dac_out          <= dac_d;
      high_rate_filter <= ctl_one_q[EYM_BIT_HIGH_RATE];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (req.addr)
      EYM_OFS_CTL_ONE:   rdata_d = ctl_one_q;
      EYM_OFS_CTL_TWO:   rdata_d = ctl_two_q;
      EYM_OFS_CTL_THREE: rdata_d = {auto_step_q, ctl3_rsvd_q, vlimit,
                                    no_open, no_hits, measure_q,
                                    active_q};
      EYM_OFS_HITS_HI:   rdata_d = hit_count_q[15:8];
      EYM_OFS_HITS_LO:   rdata_d = hit_count_q[7:0];
      EYM_OFS_RSVD_A:    rdata_d = rsvd_a_q;
      EYM_OFS_RSVD_B:    rdata_d = rsvd_b_q;
      EYM_OFS_TIMER:     rdata_d = timer_q;
      EYM_OFS_HORIZ:     rdata_d = horiz;
      EYM_OFS_VERT:      rdata_d = vert;
      EYM_OFS_CTL_FOUR:  rdata_d = ctl_four_q;
      default:           rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (req.rd)
      rdata <= rdata_d;
  end

  // ****************************************************************
  // engines
  // ****************************************************************
  eym_hit_counter u_counter (
    .mclk       (mclk),
    .rst        (rst),
    .hit_in     (hit_in),
    .vco_div_in (vco_div_in),
    .start      (count_start),
    .interval   (timer_q),
    .busy       (cnt_busy),
    .done       (cnt_done),
    .hits       (cnt_hits)
  );

  eym_opening_scan u_scan (
    .mclk      (mclk),
    .rst       (rst),
    .start     (scan_start),
    .threshold (ctl_four_q[3:0]),
    .cnt_done  (cnt_done),
    .cnt_hits  (cnt_hits),
    .cnt_start (scan_cnt_start),
    .dac       (scan_dac),
    .busy      (scan_busy),
    .done      (scan_done),
    .horiz     (horiz),
    .vert      (vert),
    .no_hits   (no_hits),
    .no_open   (no_open),
    .vlimit    (vlimit)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_low_read_step;
    rd_low && auto_step_q && !active_q && !measure_q;
  endsequence

  sequence s_count_runs;
    active_q && cnt_busy;
  endsequence

  chk_dac_override: assert property (@(posedge mclk) disable iff (rst)
    ctl_one_q[EYM_BIT_OVERRIDE] |=> dac_out.phase == $past(ctl_one_q[5:0])
    && dac_out.voltage == $past(ctl_two_q[5:0]))
    else $error("override value not on dacs");

  chk_dac_scan: assert property (@(posedge mclk) disable iff (rst)
    !ctl_one_q[EYM_BIT_OVERRIDE] && scan_busy
    |=> dac_out == $past(scan_dac))
    else $error("sweep point not on dacs");

  chk_filter_mode: assert property (@(posedge mclk) disable iff (rst)
    ##1 high_rate_filter == $past(ctl_one_q[EYM_BIT_HIGH_RATE]))
    else $error("filter mode does not follow control bit");

  chk_fast_step: assert property (@(posedge mclk) disable iff (rst)
    s_low_read_step |=> s_count_runs ##0
    auto_pt_q == $past(auto_pt_q) + 12'h001)
    else $error("low byte read did not step");

  chk_measure_clear: assert property (@(posedge mclk) disable iff (rst)
    scan_done |=> !measure_q)
    else $error("measure bit stayed after sweep");

  chk_active_clear: assert property (@(posedge mclk) disable iff (rst)
    cnt_done && !count_start |=> !active_q)
    else $error("active bit did not self-clear");

  chk_count_latch: assert property (@(posedge mclk) disable iff (rst)
    cnt_done |=> hit_count_q == $past(cnt_hits))
    else $error("hit count not captured");

  chk_flags_sweep: assert property (@(posedge mclk) disable iff (rst)
    scan_done |-> (no_hits == (horiz == 8'h40))
    && (no_open == (horiz == 8'h00)))
    else $error("flags disagree with horizontal result");

endmodule : eym_regs

`default_nettype wire

// >>> verif/eye_opening_monitor_regs_tb_top.sv
// Purpose: self-checking bench for the eye monitor register bank
// Assumes: hit input low unless enabled, then it copies the divided clock
// Notes:   sweep runs with interval 0 to keep 128 points short
`default_nettype none

module eye_opening_monitor_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eym_pkg::*;

  // ****************************************************************
  // clock, reset, stimulus
  // ****************************************************************
  logic       mclk;
  logic       rst;
  eym_req_s   req;
  logic [7:0] rdata;
  logic       vco_div_in = 1'b0;
  logic       hit_en = 1'b0;
  logic       hit_in;
  logic       high_rate_filter;
  eym_dac_s   dac_out;
  int         errors;
  int         check_count;
  int         cycles = 0;
  logic [7:0] d;
  logic [7:0] rst_vals [11] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00,
    8'h48, 8'h48, 8'h01, 8'h00, 8'h00, 8'h00};

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // gated copy: every tick is also exactly one hit edge
  assign hit_in = hit_en & vco_div_in;

  // divided vco clock toggles every two cycles: one tick per four
  always @(posedge mclk)
  begin
    if (cycles % 2 == 0)
      vco_div_in <= ~vco_div_in;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      summarize();
    end
  end

  eym_regs i_eym_regs (
    .mclk             (mclk),
    .rst              (rst),
    .req              (req),
    .rdata            (rdata),
    .hit_in           (hit_in),
    .vco_div_in       (vco_div_in),
    .dac_out          (dac_out),
    .high_rate_filter (high_rate_filter)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk);
    req.wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  // strobe taken at the edge, data stands from that edge's update on
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req.rd <= 1'b0;
    @(posedge mclk);
    v = rdata;
  endtask : rd

  // poll control three until the masked bits drop; bounded
  task automatic wait_idle(input logic [7:0] mask);
    int n;
    n = 0;
    rd(EYM_OFS_CTL_THREE, d);
    while ((d & mask) != 8'h00 && n < 3000)
    begin
      rd(EYM_OFS_CTL_THREE, d);
      n++;
    end
    check(d & mask, 8'h00);
  endtask : wait_idle

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int i = 0; i < 11; i++)
    begin
      rd(8'h22 + 8'(i), d);
      check(d, rst_vals[i]);
    end
    rd(8'h30, d);
    check(d, 8'h00);
    wr(EYM_OFS_RSVD_A, 8'ha5);
    rd(EYM_OFS_RSVD_A, d);
    check(d, 8'ha5);
    wr(EYM_OFS_CTL_FOUR, 8'hf3);
    rd(EYM_OFS_CTL_FOUR, d);
    check(d, 8'hf3);
    $display("test reset done");
  endtask : t_reset

  task automatic t_count();
    rd(EYM_OFS_HITS_HI, d);
    wr(EYM_OFS_CTL_THREE, 8'h01);
    rd(EYM_OFS_CTL_THREE, d);
    check(d[0], 1'b1);
    wait_idle(8'h01);
    rd(EYM_OFS_HITS_HI, d);
    check(d, 8'h00);
    rd(EYM_OFS_HITS_LO, d);
    check(d, 8'h00);
    $display("test count done");
  endtask : t_count

  // one unit of interval is 256 ticks, so 256 hits are expected
  task automatic t_hits();
    hit_en <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(EYM_OFS_CTL_THREE, 8'h01);
    wait_idle(8'h01);
    rd(EYM_OFS_HITS_HI, d);
    check(d, 8'h01);
    rd(EYM_OFS_HITS_LO, d);
    check(d, 8'h00);
    hit_en <= 1'b0;
    $display("test hits done");
  endtask : t_hits

  task automatic t_auto();
    wr(EYM_OFS_CTL_THREE, 8'h80);
    rd(EYM_OFS_CTL_THREE, d);
    check(d[0], 1'b1);
    wait_idle(8'h01);
    rd(EYM_OFS_HITS_LO, d);
    rd(EYM_OFS_CTL_THREE, d);
    check(d[0], 1'b1);
    check({2'h0, dac_out.phase}, 8'h01);
    check({2'h0, dac_out.voltage}, 8'h00);
    wr(EYM_OFS_CTL_ONE, 8'hc5);
    wr(EYM_OFS_CTL_TWO, 8'h3a);
    // dac outputs are registered one edge behind the control write
    @(posedge mclk);
    check({2'h0, dac_out.phase}, 8'h05);
    check({2'h0, dac_out.voltage}, 8'h3a);
    check({7'h0, high_rate_filter}, 8'h01);
    wait_idle(8'h01);
    wr(EYM_OFS_CTL_ONE, 8'h00);
    wr(EYM_OFS_CTL_THREE, 8'h00);
    check({7'h0, high_rate_filter}, 8'h00);
    $display("test auto done");
  endtask : t_auto

  task automatic t_measure();
    wr(EYM_OFS_TIMER, 8'h00);
    wr(EYM_OFS_CTL_THREE, 8'h02);
    rd(EYM_OFS_CTL_THREE, d);
    check(d[1], 1'b1);
    wait_idle(8'h02);
    check(d, 8'h14);
    rd(EYM_OFS_HORIZ, d);
    check(d, 8'h40);
    rd(EYM_OFS_VERT, d);
    check(d, 8'h40);
    $display("test measure done");
  endtask : t_measure

  initial
  begin
    rst = 1'b1;
    req = '0;
    errors = 0;
    check_count = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_count();
    t_hits();
    t_auto();
    t_measure();
    summarize();
  end

endmodule : eye_opening_monitor_regs_tb_top

`default_nettype wire
